// [rtl/res_cfg.svh]
`ifndef RES_CFG_SVH
`define RES_CFG_SVH

// Register offsets (byte addresses on the Wishbone bus, index times four)
`define RES_IDX_MASK_A        8'h10
`define RES_IDX_SRC_SEL       8'h11
`define RES_IDX_EDGE_DLY      8'h12
`define RES_IDX_STATUS        8'h13
`define RES_ADR_MASK_A        8'h40
`define RES_ADR_SRC_SEL       8'h44
`define RES_ADR_EDGE_DLY      8'h48
`define RES_ADR_STATUS        8'h4c

// Reset values, field positions and write masks
`define RES_MASK_A_RST        8'h00
`define RES_SRC_SEL_RST       8'h80
`define RES_EDGE_DLY_RST      8'h00
`define RES_SEL_LSB           2
`define RES_SEL_MSB           4
`define RES_RISE_LSB          0
`define RES_RISE_MSB          2
`define RES_FALL_LSB          3
`define RES_FALL_MSB          5
`define RES_SRC_SEL_WMASK     8'h1f
`define RES_EDGE_DLY_WMASK    8'hc0

// Timebase: one tick per millisecond at 250 MHz
`define RES_CLK_HZ            250000000
`define RES_TICK_MS           1
`define RES_TICK_CYCLES       (`RES_CLK_HZ / 1000 * `RES_TICK_MS)

`endif

// [rtl/res_pkg.sv]
package res_pkg;

	typedef enum logic [1:0] {
		RES_OFF     = 2'b00,
		RES_WAIT_ON = 2'b01,
		RES_ON      = 2'b10,
		RES_WAIT_OFF = 2'b11
	} res_state_e;

	typedef logic [2:0] res_code_t;

	typedef struct packed {
		logic [7:0]  mask_a;
		logic [7:0]  src_sel;
		logic [7:0]  edge_dly;
		logic        ack;
		logic [31:0] rdata;
		logic [1:0]  pin_s1;
		logic [6:0]  pin_s1_hi;
		logic [6:0]  pin_s2;
		logic [9:0]  pg_s1;
		logic [9:0]  pg_s2;
		res_state_e  state;
		logic [6:0]  ms_left;
		logic        rail_en;
	} res_top_s;

	typedef struct packed {
		logic [31:0] pre;
		logic        tick;
	} res_tick_s;

endpackage

// [rtl/res_tick.sv]
`timescale 1ns/1ps
`include "res_cfg.svh"

// One-cycle pulse every TICK_CYCLES clocks
module res_tick #(
	parameter int unsigned TICK_CYCLES = `RES_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	// Restart the period
	input  wire logic restart_i,
	// Tick output
	output logic      tick_o
);

	res_pkg::res_tick_s s_q;
	res_pkg::res_tick_s s_d;

	always_comb begin
		s_d      = s_q;
		s_d.tick = 1'b0;
		if (restart_i) begin
			s_d.pre = 32'h0;
		end else if (s_q.pre >= 32'(TICK_CYCLES - 1)) begin
			s_d.pre  = 32'h0;
			s_d.tick = 1'b1;
		end else begin
			s_d.pre = s_q.pre + 32'h1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick_o = s_q.tick;

endmodule

// [rtl/res_rail_enable_sequencer.sv]
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "res_cfg.svh"

// Function
// - Mask bit 7 drops regulator 3 good
// - Mask bit 6 drops regulator 2 good
// - Mask bit 5 drops load switch a
// - Mask bit 4 drops converter rail 6
// - Mask bit 3 drops converter rail 5
// - Mask bit 2 drops converter rail 3
// - Mask bit 1 drops converter rail 2
// - Mask bit 0 drops converter rail 1
// - Select bit 1 drops switch b2 pair
// - Select bit 0 drops load switch b
// - Selector picks control pin per code
// - Code 111 feeds constant one
// - Disable delay code scale to 64 ms
// - Enable delay code same scale
// - Delays within ten percent tolerance
module res_rail_enable_sequencer #(
	parameter int unsigned TICK_CYCLES = `RES_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Control pins 1..6, asynchronous
	input  wire logic        control_pin_1_i,
	input  wire logic        control_pin_2_i,
	input  wire logic        control_pin_3_i,
	input  wire logic        control_pin_4_i,
	input  wire logic        control_pin_5_i,
	input  wire logic        control_pin_6_i,
	// Sibling power good flags, asynchronous
	input  wire logic        converter_rail_1_power_good_flag_i,
	input  wire logic        converter_rail_2_power_good_flag_i,
	input  wire logic        converter_rail_3_power_good_flag_i,
	input  wire logic        converter_rail_5_power_good_flag_i,
	input  wire logic        converter_rail_6_power_good_flag_i,
	input  wire logic        load_switch_a_power_good_flag_i,
	input  wire logic        general_regulator_2_power_good_flag_i,
	input  wire logic        general_regulator_3_power_good_flag_i,
	input  wire logic        load_switch_b_power_good_flag_i,
	input  wire logic        switch_b2_regulator_1_pair_power_good_flag_i,
	// Rail enable
	output logic             target_converter_rail_enable_o
);

	res_pkg::res_top_s s_q;
	res_pkg::res_top_s s_d;

	logic       tick;
	logic       restart;
	logic [6:0] pins_raw;
	logic [9:0] pg_raw;
	logic [9:0] pg_mask;
	logic [9:0] pg_ok;
	logic       pg_all;
	logic       source;
	logic       wb_req;
	logic       wr_lane0;
	logic [6:0] rise_ms;
	logic [6:0] fall_ms;

	// Pin 3 and 4 share index 2 and 3 of the vector
	assign pins_raw = {1'b0, control_pin_6_i, control_pin_5_i, control_pin_4_i,
		control_pin_3_i, control_pin_2_i, control_pin_1_i};
	assign pg_raw = {switch_b2_regulator_1_pair_power_good_flag_i, load_switch_b_power_good_flag_i,
		general_regulator_3_power_good_flag_i, general_regulator_2_power_good_flag_i,
		load_switch_a_power_good_flag_i, converter_rail_6_power_good_flag_i,
		converter_rail_5_power_good_flag_i, converter_rail_3_power_good_flag_i,
		converter_rail_2_power_good_flag_i, converter_rail_1_power_good_flag_i};

	// Mask order follows pg_raw; low eight come from the first mask register
	assign pg_mask = {s_q.src_sel[1], s_q.src_sel[0], s_q.mask_a};

	// A masked flag counts as good
	genvar gi;
	generate
		for (gi = 0; gi < 10; gi++) begin : g_pg
			assign pg_ok[gi] = s_q.pg_s2[gi] | pg_mask[gi];
		end
	endgenerate
	assign pg_all = &pg_ok;

	// Delay code to milliseconds
	function automatic logic [6:0] code_ms(input res_pkg::res_code_t c);
		logic [6:0] ms;
		ms = 7'd0;
		case (c)
			3'b000: ms = 7'd0;
			3'b001: ms = 7'd2;
			3'b010: ms = 7'd4;
			3'b011: ms = 7'd8;
			3'b100: ms = 7'd16;
			3'b101: ms = 7'd24;
			3'b110: ms = 7'd32;
			3'b111: ms = 7'd64;
			default: ms = 7'd0;
		endcase
		return ms;
	endfunction

	assign rise_ms = code_ms(s_q.edge_dly[`RES_RISE_MSB:`RES_RISE_LSB]);
	assign fall_ms = code_ms(s_q.edge_dly[`RES_FALL_MSB:`RES_FALL_LSB]);

	// Source multiplexer
	always_comb begin
		source = 1'b0;
		case (s_q.src_sel[`RES_SEL_MSB:`RES_SEL_LSB])
			3'b000: source = s_q.pin_s2[0];
			3'b001: source = s_q.pin_s2[1];
			3'b010: source = s_q.pin_s2[4];
			3'b011: source = s_q.pin_s2[3];
			3'b100: source = s_q.pin_s2[2];
			3'b101: source = s_q.pin_s2[2] & s_q.pin_s2[3];
			3'b110: source = s_q.pin_s2[5];
			3'b111: source = 1'b1;
			default: source = 1'b0;
		endcase
	end

	// Restart the millisecond timebase whenever a wait begins, so the first tick is a full period
	assign restart = (s_q.state == res_pkg::RES_OFF && source)
		|| (s_q.state == res_pkg::RES_ON && !source)
		|| (s_q.state == res_pkg::RES_WAIT_ON && !source)
		|| (s_q.state == res_pkg::RES_WAIT_OFF && source);

	res_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.ref_clk_i(ref_clk_i),
		.reset_i  (reset_i),
		.restart_i(restart),
		.tick_o   (tick)
	);

	assign wb_req   = wb_cyc_i & wb_stb_i & ~s_q.ack;
	assign wr_lane0 = wb_req & wb_we_i & wb_sel_i[0];

	always_comb begin
		s_d       = s_q;
		s_d.ack   = wb_req;
		// Two flops on every asynchronous input
		s_d.pin_s1_hi = pins_raw;
		s_d.pin_s2    = s_q.pin_s1_hi;
		s_d.pin_s1    = 2'b00;
		s_d.pg_s1     = pg_raw;
		s_d.pg_s2     = s_q.pg_s1;

		if (wr_lane0) begin
			case (wb_adr_i)
				`RES_ADR_MASK_A:   s_d.mask_a = wb_dat_i[7:0];
				`RES_ADR_SRC_SEL:  s_d.src_sel = wb_dat_i[7:0] & `RES_SRC_SEL_WMASK | `RES_SRC_SEL_RST;
				`RES_ADR_EDGE_DLY: s_d.edge_dly = wb_dat_i[7:0] & ~`RES_EDGE_DLY_WMASK;
				default: ;
			endcase
		end
		s_d.rdata = 32'h0;
		if (wb_req && !wb_we_i) begin
			case (wb_adr_i)
				`RES_ADR_MASK_A:   s_d.rdata = {24'h0, s_q.mask_a};
				`RES_ADR_SRC_SEL:  s_d.rdata = {24'h0, s_q.src_sel};
				`RES_ADR_EDGE_DLY: s_d.rdata = {24'h0, s_q.edge_dly};
				`RES_ADR_STATUS:   s_d.rdata = {21'h0, s_q.rail_en, s_q.state, pg_all, source,
					s_q.ms_left[6:2], 1'b0} >> 1;
				default:           s_d.rdata = 32'h0;
			endcase
		end

		// Timing counts whole ticks of 1 ms, so the delay is exact within one clock
		case (s_q.state)
			res_pkg::RES_OFF: begin
				if (source) begin
					if (rise_ms == 7'd0) begin
						s_d.state = res_pkg::RES_ON;
					end else begin
						s_d.state   = res_pkg::RES_WAIT_ON;
						s_d.ms_left = rise_ms;
					end
				end
			end
			res_pkg::RES_WAIT_ON: begin
				if (!source) begin
					s_d.state = res_pkg::RES_OFF;
				end else if (tick) begin
					if (s_q.ms_left == 7'd1) begin
						s_d.state = res_pkg::RES_ON;
					end
					s_d.ms_left = s_q.ms_left - 7'd1;
				end
			end
			res_pkg::RES_ON: begin
				if (!source) begin
					if (fall_ms == 7'd0) begin
						s_d.state = res_pkg::RES_OFF;
					end else begin
						s_d.state   = res_pkg::RES_WAIT_OFF;
						s_d.ms_left = fall_ms;
					end
				end
			end
			res_pkg::RES_WAIT_OFF: begin
				if (source) begin
					s_d.state = res_pkg::RES_ON;
				end else if (tick) begin
					if (s_q.ms_left == 7'd1) begin
						s_d.state = res_pkg::RES_OFF;
					end
					s_d.ms_left = s_q.ms_left - 7'd1;
				end
			end
			default: s_d.state = res_pkg::RES_OFF;
		endcase

		// Rail stays on through the falling wait; power good gates it at all times
		s_d.rail_en = (s_d.state == res_pkg::RES_ON || s_d.state == res_pkg::RES_WAIT_OFF)
			&& pg_all;
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			s_q          <= '0;
			s_q.src_sel  <= `RES_SRC_SEL_RST;
			s_q.edge_dly <= `RES_EDGE_DLY_RST;
			s_q.mask_a   <= `RES_MASK_A_RST;
			s_q.state    <= res_pkg::RES_OFF;
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_ack_o = s_q.ack;
	assign wb_dat_o = s_q.rdata;
	assign target_converter_rail_enable_o = s_q.rail_en;

endmodule

// [bench/res_rail_enable_sequencer_props.sv]
`timescale 1ns/1ps
module res_rail_enable_sequencer_props (
	// Clock, reset and bus
	input wire logic        ref_clk_i,
	input wire logic        reset_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Goods and enable
	input wire logic        converter_rail_1_power_good_flag_i,
	input wire logic        general_regulator_3_power_good_flag_i,
	input wire logic        target_converter_rail_enable_o
);
	logic [7:0] m_q;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	// Mask copy lags the design by one cycle, so it only errs towards leniency
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			m_q <= 8'h00;
		else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h40)
			m_q <= wb_dat_i[7:0];
	end
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_reset_idle: assert property (disable iff (1'b0) reset_i |=> !wb_ack_o && !target_converter_rail_enable_o)
		else $error("outputs active in reset");
	chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h50 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_mask_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h40 |-> wb_dat_o[7:0] == m_q)
		else $error("mask readback wrong");
	chk_rail1_good: assert property ((!converter_rail_1_power_good_flag_i && !m_q[0]) [*6] |-> !target_converter_rail_enable_o)
		else $error("enabled without rail 1 good");
	chk_reg3_good: assert property ((!general_regulator_3_power_good_flag_i && !m_q[7]) [*6] |-> !target_converter_rail_enable_o)
		else $error("enabled without regulator 3 good");
	cover property ($rose(target_converter_rail_enable_o));
	cover property ($fell(target_converter_rail_enable_o));
	cover property (wb_ack_o && wb_we_i);
endmodule
bind res_rail_enable_sequencer res_rail_enable_sequencer_props i_chk (.*);

// [bench/res_far_model.sv]
`timescale 1ns/1ps
module res_far_model (
	// Clock
	input  wire logic       ref_clk_i,
	// Levels asked for by the bench
	input  wire logic [5:0] pin_set_i,
	input  wire logic [9:0] pg_set_i,
	// Levels at the pins
	output logic [5:0]      pin_o,
	output logic [9:0]      pg_o
);
	// Pins move after an edge only, never in the sampling step
	always_ff @(posedge ref_clk_i) begin
		pin_o <= pin_set_i;
		pg_o  <= pg_set_i;
	end
endmodule

// [bench/tb_res_rail_enable_sequencer.sv]
`timescale 1ns/1ps
module tb_res_rail_enable_sequencer;
	localparam int TK = 10;
	logic        ref_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        target_converter_rail_enable_o;
	logic [5:0]  pin_set = 6'h00;
	logic [9:0]  pg_set = 10'h3ff;
	logic [5:0]  pin_o;
	logic [9:0]  pg_o;
	int          num_errors = 0;
	int          n_tests = 0;
	int          ms[8] = '{0, 2, 4, 8, 16, 24, 32, 64};
	logic [5:0]  pm[8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0c, 6'h20, 6'h00};
	wire logic   control_pin_1_i = pin_o[0], control_pin_2_i = pin_o[1], control_pin_3_i = pin_o[2];
	wire logic   control_pin_4_i = pin_o[3], control_pin_5_i = pin_o[4], control_pin_6_i = pin_o[5];
	wire logic   converter_rail_1_power_good_flag_i = pg_o[0], converter_rail_2_power_good_flag_i = pg_o[1];
	wire logic   converter_rail_3_power_good_flag_i = pg_o[2], converter_rail_5_power_good_flag_i = pg_o[3];
	wire logic   converter_rail_6_power_good_flag_i = pg_o[4], load_switch_a_power_good_flag_i = pg_o[5];
	wire logic   general_regulator_2_power_good_flag_i = pg_o[6], general_regulator_3_power_good_flag_i = pg_o[7];
	wire logic   load_switch_b_power_good_flag_i = pg_o[8], switch_b2_regulator_1_pair_power_good_flag_i = pg_o[9];
	res_far_model i_far (.ref_clk_i(ref_clk_i), .pin_set_i(pin_set), .pg_set_i(pg_set), .pin_o(pin_o), .pg_o(pg_o));
	res_rail_enable_sequencer #(.TICK_CYCLES(TK)) i_dut (.*);
	initial begin
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk_i);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
		int i;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h000000, d};
		i = 0;
		do begin
			@(posedge ref_clk_i);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 50);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk_i);
		if (i >= 50) begin
			num_errors++;
			finish_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 8'h00, r);
		chk(r, e);
	endtask
	// Bounded wait for the enable level, returns the cycles it took
	task automatic ween(input logic v, output int n);
		n = 0;
		while (target_converter_rail_enable_o !== v && n < 2000) begin
			@(posedge ref_clk_i);
			n++;
		end
		if (n >= 2000) begin
			num_errors++;
			finish_test();
		end
	endtask
	initial begin
		int n;
		int e;
		tick(4);
		reset_i <= 1'b0;
		rd(8'h40, 32'h00);
		rd(8'h44, 32'h80);
		rd(8'h48, 32'h00);
		rd(8'h50, 32'h00);
		wr(8'h44, 8'hff);
		rd(8'h44, 32'h9f);
		wr(8'h48, 8'hff);
		rd(8'h48, 32'h3f);
		wr(8'h40, 8'ha5);
		wb_sel_i <= 4'he;
		wr(8'h40, 8'hff);
		wb_sel_i <= 4'hf;
		rd(8'h40, 32'ha5);
		wr(8'h40, 8'h00);
		wr(8'h48, 8'h00);
		$display("register test done");
		for (int c = 0; c < 8; c++) begin
			wr(8'h44, 8'(c << 2));
			pin_set <= ~pm[c];
			tick(20);
			chk(target_converter_rail_enable_o, c == 7);
			pin_set <= pm[c] & (pm[c] - 6'h01);
			tick(20);
			chk(target_converter_rail_enable_o, c == 7);
			pin_set <= pm[c];
			ween(1'b1, n);
			pin_set <= 6'h00;
			ween(c == 7, n);
		end
		$display("selector test done");
		wr(8'h44, 8'h00);
		for (int c = 0; c < 8; c++) begin
			e = ms[c] * TK;
			wr(8'h48, 8'((c << 3) | c));
			pin_set <= 6'h01;
			ween(1'b1, n);
			chk(n >= e * 9 / 10 && n <= e * 11 / 10 + 12, 1);
			pin_set <= 6'h00;
			ween(1'b0, n);
			chk(n >= e * 9 / 10 && n <= e * 11 / 10 + 12, 1);
		end
		$display("delay test done");
		wr(8'h48, 8'h12);
		pin_set <= 6'h01;
		tick(20);
		pin_set <= 6'h00;
		tick(5);
		pin_set <= 6'h01;
		ween(1'b1, n);
		chk(n >= 36 && n <= 56, 1);
		pin_set <= 6'h00;
		tick(20);
		pin_set <= 6'h01;
		tick(60);
		chk(target_converter_rail_enable_o, 1);
		pin_set <= 6'h00;
		ween(1'b0, n);
		$display("restart test done");
		wr(8'h48, 8'h00);
		wr(8'h44, 8'h1c);
		for (int k = 0; k < 10; k++) begin
			ween(1'b1, n);
			pg_set <= ~(10'h001 << k);
			tick(20);
			chk(target_converter_rail_enable_o, 0);
			if (k < 8)
				wr(8'h40, 8'(1 << k));
			else
				wr(8'h44, 8'(8'h1c | (1 << (k - 8))));
			ween(1'b1, n);
			pg_set <= 10'h3ff;
			wr(8'h40, 8'h00);
			wr(8'h44, 8'h1c);
		end
		$display("good flag test done");
		reset_i <= 1'b1;
		tick(4);
		chk(target_converter_rail_enable_o, 0);
		reset_i <= 1'b0;
		rd(8'h44, 32'h80);
		$display("second reset test done");
		finish_test();
	end
endmodule
